/* logic/retry_pkg.sv */
package retry_pkg;
    // Pack geometry and track capacity
    localparam int unsigned TRACK_BYTES     = 13030;
    localparam int unsigned PRIMARY_CYLS    = 404;
    localparam int unsigned ALTERNATE_CYLS  = 7;
    localparam int unsigned TRACKS_PER_CYL  = 19;
    localparam int unsigned TOTAL_CYLS      = PRIMARY_CYLS + ALTERNATE_CYLS;
    localparam logic [8:0]  LAST_CYL        = 9'(TOTAL_CYLS - 1);
    localparam logic [4:0]  LAST_HEAD       = 5'(TRACKS_PER_CYL - 1);
    localparam logic [13:0] TRACK_BYTES_W   = 14'(TRACK_BYTES);

    // Retry limits
    localparam logic [3:0]  DATA_RETRY_MAX  = 4'h2;
    localparam logic [3:0]  SEEK_RETRY_MAX  = 4'hA;
    localparam logic [3:0]  ONE_RETRY       = 4'h1;

    // Error log: one entry per successful retry
    localparam int unsigned LOG_AW          = 6;
    localparam int unsigned LOG_DW          = 16;
    localparam int unsigned UCODE_AW        = 12;
    localparam logic [11:0] UCODE_LAST      = 12'hFFF;

    // Retry cause codes
    typedef enum logic [2:0] {
        CAUSE_NONE    = 3'h0,
        CAUSE_CORR    = 3'h1,
        CAUSE_UNCORR  = 3'h2,
        CAUSE_SEEK    = 3'h3,
        CAUSE_ALT     = 3'h4,
        CAUSE_OVERRUN = 3'h5
    } cause_t;

    typedef enum logic [7:0] {
        ST_LOAD    = 8'h01,
        ST_IDLE    = 8'h02,
        ST_EXEC    = 8'h04,
        ST_DISC    = 8'h08,
        ST_ALTSEEK = 8'h10,
        ST_ORIENT  = 8'h20,
        ST_REISSUE = 8'h40,
        ST_FAIL    = 8'h80
    } state_t;

    // ECC check field: simple byte-wise syndrome
    localparam logic [7:0]  ECC_SEED        = 8'hFF;
endpackage

/* logic/retry_log_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module retry_log_mem (
    input  wire logic                          core_clk_i,
    input  wire logic                          we_i,
    input  wire logic [retry_pkg::LOG_AW-1:0]  waddr_i,
    input  wire logic [retry_pkg::LOG_DW-1:0]  wdata_i,
    input  wire logic [retry_pkg::LOG_AW-1:0]  raddr_i,
    output logic      [retry_pkg::LOG_DW-1:0]  rdata_o
);
    logic [retry_pkg::LOG_DW-1:0] mem [2**retry_pkg::LOG_AW];

    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule
`default_nettype wire

/* logic/disk_command_retry_recovery.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Correctable data-portion error yields sense pattern plus byte displacement.
// - Listed retries re-execute the command with no interrupt to software.
// - Buffer HA/count/key fields; on correctable error fix buffer and reissue.
// - Disconnect from channel while reorienting for that retry.
// - Retried command uses corrected buffered field instead of track data.
// - Uncorrectable data error: reissue command word at most two times.
// - Seek malfunction: retry seek at most ten times.
// - Alternate track: read descriptor location, seek, orient, reissue command.
// - Overrun or late chaining starts a retry of the late command.
// - Each successful retry is logged in control storage.
// - ECC field appended on write of every area, checked on read.
// - Load microprogram from cartridge into control storage at power-on.
// - Full-track transfers bounded to 13030 bytes.
// - Geometry: 404 plus 7 alternate cylinders, 19 tracks each.
module disk_command_retry_recovery (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Microprogram load from cartridge reader
    input  wire logic        ucode_valid_i,
    input  wire logic [7:0]  ucode_byte_i,
    output logic             ucode_ready_o,
    output logic             ucode_we_o,
    output logic [11:0]      ucode_addr_o,
    output logic [7:0]       ucode_data_o,
    output logic             online_o,
    // Command from channel
    input  wire logic        cmd_start_i,
    input  wire logic [7:0]  channel_command_word_i,
    input  wire logic [8:0]  cmd_cyl_i,
    input  wire logic [4:0]  cmd_head_i,
    input  wire logic [13:0] cmd_len_i,
    output logic             cmd_accept_o,
    output logic             cmd_reject_o,
    // Drive-side execution
    output logic             exec_go_o,
    output logic [7:0]       exec_cmd_o,
    output logic [8:0]       exec_cyl_o,
    output logic [4:0]       exec_head_o,
    output logic [13:0]      exec_len_o,
    output logic             exec_use_buffer_o,
    input  wire logic        exec_done_i,
    input  wire logic        err_corr_field_i,
    input  wire logic        err_corr_data_i,
    input  wire logic        err_uncorr_i,
    input  wire logic        err_seek_i,
    input  wire logic        err_alt_track_i,
    input  wire logic        err_overrun_i,
    input  wire logic [15:0] err_pattern_i,
    input  wire logic [15:0] err_disp_i,
    // Field buffer of home address, count or key read
    input  wire logic        field_we_i,
    input  wire logic [63:0] field_data_i,
    output logic [63:0]      field_buf_o,
    // Alternate location from track descriptor record
    input  wire logic        alt_valid_i,
    input  wire logic [8:0]  alt_cyl_i,
    input  wire logic [4:0]  alt_head_i,
    input  wire logic        orient_index_i,
    input  wire logic        reorient_done_i,
    // Channel status
    output logic             disconnect_o,
    output logic             ending_ok_o,
    output logic             ending_err_o,
    output logic [15:0]      sense_pattern_o,
    output logic [15:0]      sense_disp_o,
    output logic [2:0]       sense_cause_o,
    // ECC on recorded areas
    input  wire logic        wr_byte_valid_i,
    input  wire logic [7:0]  wr_byte_i,
    input  wire logic        wr_area_end_i,
    output logic             wr_ecc_valid_o,
    output logic [7:0]       wr_ecc_o,
    input  wire logic        rd_byte_valid_i,
    input  wire logic [7:0]  rd_byte_i,
    input  wire logic        rd_area_end_i,
    input  wire logic [7:0]  rd_ecc_i,
    output logic             rd_ecc_err_o,
    // Error log readback
    input  wire logic [5:0]  log_raddr_i,
    output logic [15:0]      log_rdata_o,
    output logic [5:0]       log_count_o
);
    retry_pkg::state_t state;
    retry_pkg::state_t next_state;
    retry_pkg::cause_t cause;
    logic [3:0]  tries;
    logic [11:0] ucode_ptr;
    logic [7:0]  cur_cmd;
    logic [8:0]  cur_cyl;
    logic [4:0]  cur_head;
    logic [13:0] cur_len;
    logic        use_buf;
    logic [7:0]  wr_syn;
    logic [7:0]  rd_syn;
    logic        any_err;
    logic        retrying;
    logic        limit_hit;
    logic        cmd_ok;
    logic        log_we;
    logic [5:0]  log_ptr;

    function automatic logic [7:0] ecc_step(input logic [7:0] syn, input logic [7:0] b);
        ecc_step = {syn[6:0], syn[7]} ^ b;
    endfunction

    function automatic logic [3:0] retry_limit(input retry_pkg::cause_t c);
        case (c)
            retry_pkg::CAUSE_UNCORR: retry_limit = retry_pkg::DATA_RETRY_MAX;
            retry_pkg::CAUSE_SEEK:   retry_limit = retry_pkg::SEEK_RETRY_MAX;
            default:                 retry_limit = retry_pkg::ONE_RETRY;
        endcase
    endfunction

    // Geometry and length checks
    assign cmd_ok = (cmd_cyl_i <= retry_pkg::LAST_CYL)
                 && (cmd_head_i <= retry_pkg::LAST_HEAD)
                 && (cmd_len_i <= retry_pkg::TRACK_BYTES_W);

    assign any_err = err_corr_field_i | err_corr_data_i | err_uncorr_i
                   | err_seek_i | err_alt_track_i | err_overrun_i;
    assign limit_hit    = (tries >= retry_limit(cause));
    assign retrying     = (tries != 4'h0);
    assign ucode_ready_o = (state == retry_pkg::ST_LOAD);
    assign ucode_we_o   = ucode_ready_o & ucode_valid_i;
    assign ucode_addr_o = ucode_ptr;
    assign ucode_data_o = ucode_byte_i;
    assign online_o     = (state != retry_pkg::ST_LOAD);
    assign cmd_accept_o = (state == retry_pkg::ST_IDLE) & cmd_start_i & cmd_ok;
    assign cmd_reject_o = (state == retry_pkg::ST_IDLE) & cmd_start_i & ~cmd_ok;
    assign disconnect_o = (state == retry_pkg::ST_DISC)
                       || (state == retry_pkg::ST_ALTSEEK)
                       || (state == retry_pkg::ST_ORIENT);
    assign log_we = (state == retry_pkg::ST_EXEC) & exec_done_i & ~any_err & retrying;
    assign exec_cmd_o = cur_cmd;
    assign exec_cyl_o = cur_cyl;
    assign exec_head_o = cur_head;
    assign exec_len_o = cur_len;
    assign exec_use_buffer_o = use_buf;
    assign log_count_o = log_ptr;

    // Retries go straight back to the drive; channel sees no interrupt
    always_comb begin
        next_state = state;
        case (state)
            retry_pkg::ST_LOAD: begin
                if (ucode_we_o && ucode_ptr == retry_pkg::UCODE_LAST) begin
                    next_state = retry_pkg::ST_IDLE;
                end
            end
            retry_pkg::ST_IDLE: begin
                if (cmd_accept_o) begin
                    next_state = retry_pkg::ST_EXEC;
                end
            end
            retry_pkg::ST_EXEC: begin
                if (exec_done_i) begin
                    if (!any_err || err_corr_data_i) begin
                        next_state = retry_pkg::ST_IDLE;
                    end else if (limit_hit) begin
                        next_state = retry_pkg::ST_FAIL;
                    end else if (err_corr_field_i) begin
                        next_state = retry_pkg::ST_DISC;
                    end else if (err_alt_track_i) begin
                        next_state = retry_pkg::ST_ALTSEEK;
                    end else begin
                        next_state = retry_pkg::ST_REISSUE;
                    end
                end
            end
            retry_pkg::ST_DISC: begin
                if (reorient_done_i) begin
                    next_state = retry_pkg::ST_REISSUE;
                end
            end
            retry_pkg::ST_ALTSEEK: begin
                if (alt_valid_i) begin
                    next_state = retry_pkg::ST_ORIENT;
                end
            end
            retry_pkg::ST_ORIENT: begin
                if (orient_index_i) begin
                    next_state = retry_pkg::ST_REISSUE;
                end
            end
            retry_pkg::ST_REISSUE: next_state = retry_pkg::ST_EXEC;
            retry_pkg::ST_FAIL:    next_state = retry_pkg::ST_IDLE;
            default:               next_state = retry_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= retry_pkg::ST_LOAD;
            ucode_ptr <= 12'h000;
        end else begin
            state <= next_state;
            if (ucode_we_o) begin
                ucode_ptr <= ucode_ptr + 12'h001;
            end
        end
    end

    // Command context and retry counting
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_cmd <= 8'h00;
            cur_cyl <= 9'h000;
            cur_head <= 5'h00;
            cur_len <= 14'h0000;
            tries <= 4'h0;
            cause <= retry_pkg::CAUSE_NONE;
            use_buf <= 1'b0;
        end else if (cmd_accept_o) begin
            cur_cmd <= channel_command_word_i;
            cur_cyl <= cmd_cyl_i;
            cur_head <= cmd_head_i;
            cur_len <= cmd_len_i;
            tries <= 4'h0;
            cause <= retry_pkg::CAUSE_NONE;
            use_buf <= 1'b0;
        end else if (state == retry_pkg::ST_EXEC && exec_done_i && any_err) begin
            if (err_corr_field_i) begin
                cause <= retry_pkg::CAUSE_CORR;
                use_buf <= 1'b1;
            end else if (err_uncorr_i) begin
                cause <= retry_pkg::CAUSE_UNCORR;
            end else if (err_seek_i) begin
                cause <= retry_pkg::CAUSE_SEEK;
            end else if (err_alt_track_i) begin
                cause <= retry_pkg::CAUSE_ALT;
            end else if (err_overrun_i) begin
                cause <= retry_pkg::CAUSE_OVERRUN;
            end
        end else if (state == retry_pkg::ST_ALTSEEK && alt_valid_i) begin
            cur_cyl <= alt_cyl_i;
            cur_head <= alt_head_i;
        end else if (state == retry_pkg::ST_REISSUE) begin
            tries <= tries + 4'h1;
        end
    end

    // Limit compares against the cause latched on the previous error
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            exec_go_o <= 1'b0;
            ending_ok_o <= 1'b0;
            ending_err_o <= 1'b0;
        end else begin
            exec_go_o <= cmd_accept_o || (state == retry_pkg::ST_REISSUE);
            ending_ok_o <= (state == retry_pkg::ST_EXEC) && exec_done_i
                        && (!any_err || err_corr_data_i);
            ending_err_o <= (next_state == retry_pkg::ST_FAIL);
        end
    end

    // Sense data held until the next command
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sense_pattern_o <= 16'h0000;
            sense_disp_o <= 16'h0000;
            sense_cause_o <= 3'h0;
        end else if (cmd_accept_o) begin
            sense_pattern_o <= 16'h0000;
            sense_disp_o <= 16'h0000;
            sense_cause_o <= 3'h0;
        end else if (state == retry_pkg::ST_EXEC && exec_done_i && any_err) begin
            sense_pattern_o <= err_pattern_i;
            sense_disp_o <= err_disp_i;
            sense_cause_o <= err_corr_data_i ? 3'(retry_pkg::CAUSE_CORR) : 3'(cause);
        end
    end

    // Field buffer; corrected in place on a correctable field error
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            field_buf_o <= 64'h0000000000000000;
        end else if (state == retry_pkg::ST_EXEC && exec_done_i && err_corr_field_i) begin
            field_buf_o <= field_buf_o ^ ({48'h000000000000, err_pattern_i}
                           << {err_disp_i[2:0], 3'h0});
        end else if (field_we_i && !use_buf) begin
            field_buf_o <= field_data_i;
        end
    end

    // ECC generation and check per recorded area
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_syn <= retry_pkg::ECC_SEED;
            rd_syn <= retry_pkg::ECC_SEED;
            wr_ecc_valid_o <= 1'b0;
            wr_ecc_o <= 8'h00;
            rd_ecc_err_o <= 1'b0;
        end else begin
            wr_ecc_valid_o <= wr_area_end_i;
            rd_ecc_err_o <= rd_area_end_i && (rd_syn != rd_ecc_i);
            if (wr_area_end_i) begin
                wr_ecc_o <= wr_syn;
                wr_syn <= retry_pkg::ECC_SEED;
            end else if (wr_byte_valid_i) begin
                wr_syn <= ecc_step(wr_syn, wr_byte_i);
            end
            if (rd_area_end_i) begin
                rd_syn <= retry_pkg::ECC_SEED;
            end else if (rd_byte_valid_i) begin
                rd_syn <= ecc_step(rd_syn, rd_byte_i);
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            log_ptr <= 6'h00;
        end else if (log_we) begin
            log_ptr <= log_ptr + 6'h01;
        end
    end

    retry_log_mem u_log (
        .core_clk_i (core_clk_i),
        .we_i       (log_we),
        .waddr_i    (log_ptr),
        .wdata_i    ({cur_cmd, 1'b0, 3'(cause), tries}),
        .raddr_i    (log_raddr_i),
        .rdata_o    (log_rdata_o)
    );
endmodule
`default_nettype wire

/* bench/disk_command_retry_recovery_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module retry_checker (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        ucode_valid_i,
    input wire logic [7:0]  ucode_byte_i,
    input wire logic        ucode_ready_o,
    input wire logic        ucode_we_o,
    input wire logic [11:0] ucode_addr_o,
    input wire logic [7:0]  ucode_data_o,
    input wire logic        online_o,
    input wire logic        cmd_start_i,
    input wire logic [8:0]  cmd_cyl_i,
    input wire logic [4:0]  cmd_head_i,
    input wire logic [13:0] cmd_len_i,
    input wire logic        cmd_accept_o,
    input wire logic        cmd_reject_o,
    input wire logic        exec_go_o,
    input wire logic [8:0]  exec_cyl_o,
    input wire logic [4:0]  exec_head_o,
    input wire logic [13:0] exec_len_o,
    input wire logic        disconnect_o,
    input wire logic        ending_ok_o,
    input wire logic        ending_err_o,
    input wire logic [5:0]  log_count_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire logic bad_cmd;
    assign bad_cmd = cmd_cyl_i > retry_pkg::LAST_CYL || cmd_head_i > retry_pkg::LAST_HEAD
                     || cmd_len_i > retry_pkg::TRACK_BYTES_W;
    a_accept_then_go: assert property (cmd_accept_o |=> exec_go_o)
        else $error("no go after accept");
    a_bounds_refused: assert property (cmd_start_i && bad_cmd |-> !cmd_accept_o)
        else $error("out of range command accepted");
    a_reject_cause: assert property (cmd_reject_o |-> cmd_start_i && bad_cmd ##1 !exec_go_o)
        else $error("reject without cause");
    a_exec_in_range: assert property (exec_go_o |-> exec_cyl_o <= retry_pkg::LAST_CYL
        && exec_head_o <= retry_pkg::LAST_HEAD && exec_len_o <= retry_pkg::TRACK_BYTES_W)
        else $error("executed address out of range");
    a_ucode_strobe: assert property (ucode_we_o == (ucode_valid_i && ucode_ready_o)
        && ucode_data_o == ucode_byte_i) else $error("load strobe wrong");
    a_ucode_addr_step: assert property (ucode_we_o && $past(ucode_we_o)
        |-> ucode_addr_o == $past(ucode_addr_o) + 12'h001) else $error("load address skipped");
    a_offline_no_cmd: assert property (!online_o |-> !cmd_accept_o)
        else $error("command before load done");
    a_disc_quiet: assert property (disconnect_o |->
        !exec_go_o && !ending_ok_o && !ending_err_o) else $error("activity while disconnected");
    a_end_single: assert property ((ending_ok_o || ending_err_o) |->
        !(ending_ok_o && ending_err_o) ##1 !ending_ok_o && !ending_err_o)
        else $error("ending status malformed");
    a_reissue_go: assert property ($fell(disconnect_o) |-> ##[0:2] exec_go_o)
        else $error("no reissue after reorientation");
    a_log_step: assert property ($changed(log_count_o)
        |-> log_count_o == $past(log_count_o) + 6'h01) else $error("log count jumped");
endmodule
`default_nettype wire

/* bench/drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_model (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       exec_go_i,
    input  wire logic       disconnect_i,
    input  wire logic       load_i,
    input  wire logic [3:0] fails_i,
    input  wire logic [5:0] mask_i,
    input  wire logic [2:0] lat_i,
    output logic            exec_done_o,
    output logic [5:0]      err_o,
    output logic            alt_valid_o,
    output logic            orient_o,
    output logic            reorient_o
);
    logic [3:0] left;
    logic [2:0] wait_cnt;
    logic       busy;
    logic [2:0] disc_cnt;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {left, wait_cnt, busy, disc_cnt, exec_done_o, err_o} <= '0;
            {alt_valid_o, orient_o, reorient_o} <= '0;
        end else begin
            exec_done_o <= 1'b0;
            err_o <= 6'h00;
            if (load_i) left <= fails_i;
            if (exec_go_i) begin
                busy <= 1'b1;
                wait_cnt <= lat_i;
            end else if (busy && wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end else if (busy) begin
                // Every issue executes again, failing while tries remain
                busy <= 1'b0;
                exec_done_o <= 1'b1;
                if (left != 4'h0) begin
                    err_o <= mask_i;
                    left <= left - 4'h1;
                end
            end
            // Descriptor location, index and reorientation only while away
            disc_cnt <= disconnect_i ? disc_cnt + 3'(disc_cnt != 3'h7) : 3'h0;
            alt_valid_o <= disconnect_i && disc_cnt == 3'h2;
            orient_o <= disconnect_i && disc_cnt == 3'h5;
            reorient_o <= disconnect_i && disc_cnt == 3'h5;
        end
    end
endmodule
`default_nettype wire

/* bench/disk_command_retry_recovery_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module disk_command_retry_recovery_tb;
    logic        core_clk_i, rst_i, ucode_valid_i, ucode_ready_o, ucode_we_o, online_o;
    logic        cmd_start_i, cmd_accept_o, cmd_reject_o, exec_go_o, exec_use_buffer_o;
    logic        exec_done_i, field_we_i, alt_valid_i, orient_index_i, reorient_done_i;
    logic        err_corr_field_i, err_corr_data_i, err_uncorr_i, err_seek_i;
    logic        err_alt_track_i, err_overrun_i, disconnect_o, ending_ok_o, ending_err_o;
    logic        wr_byte_valid_i, wr_area_end_i, wr_ecc_valid_o, rd_byte_valid_i;
    logic        rd_area_end_i, rd_ecc_err_o, load, last_disc, last_ub;
    logic [7:0]  ucode_byte_i, ucode_data_o, channel_command_word_i, exec_cmd_o;
    logic [7:0]  wr_byte_i, wr_ecc_o, rd_byte_i, rd_ecc_i;
    logic [11:0] ucode_addr_o;
    logic [8:0]  cmd_cyl_i, exec_cyl_o, alt_cyl_i, last_cyl;
    logic [4:0]  cmd_head_i, exec_head_o, alt_head_i;
    logic [13:0] cmd_len_i, exec_len_o;
    logic [15:0] err_pattern_i, err_disp_i, sense_pattern_o, sense_disp_o, log_rdata_o;
    logic [63:0] field_data_i, field_buf_o;
    logic [2:0]  sense_cause_o, lat;
    logic [5:0]  log_raddr_i, log_count_o, mask, errv, exp_log;
    logic [3:0]  fails;
    logic [31:0] rng;
    int          n_fail, n_tests, k;
    assign {err_overrun_i, err_alt_track_i, err_seek_i} = errv[5:3];
    assign {err_uncorr_i, err_corr_data_i, err_corr_field_i} = errv[2:0];
    disk_command_retry_recovery DUT (.*);
    drive_model u_drive (.core_clk_i, .rst_i, .exec_go_i(exec_go_o), .disconnect_i(disconnect_o),
        .load_i(load), .fails_i(fails), .mask_i(mask), .lat_i(lat), .exec_done_o(exec_done_i),
        .err_o(errv), .alt_valid_o(alt_valid_i), .orient_o(orient_index_i),
        .reorient_o(reorient_done_i));
    always #2 core_clk_i = ~core_clk_i;
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_out(input int i, input int lim);
        if (i >= lim) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic run(input logic [5:0] m, input logic [3:0] f, input logic ok,
                       input int n_go, input logic [2:0] cause, input logic edge_case);
        int goes;
        int i;
        logic [63:0] host;
        @(posedge core_clk_i);
        {mask, fails, load, cmd_start_i, lat} <= {m, f, 1'b1, 1'b1, 3'(xs())};
        channel_command_word_i <= 8'(xs());
        cmd_cyl_i <= edge_case ? retry_pkg::LAST_CYL : 9'(xs() % 411);
        cmd_head_i <= edge_case ? retry_pkg::LAST_HEAD : 5'(xs() % 19);
        cmd_len_i <= edge_case ? retry_pkg::TRACK_BYTES_W : 14'(xs() % 13031);
        {err_pattern_i, err_disp_i} <= xs();
        log_raddr_i <= exp_log;
        i = 0;
        do begin
            @(negedge core_clk_i);
            i++;
        end while (cmd_accept_o !== 1'b1 && i < 20);
        wait_out(i, 20);
        @(posedge core_clk_i);
        {load, cmd_start_i} <= 2'h0;
        goes = 0;
        last_disc = 1'b0;
        for (i = 0; i < 400 && ending_ok_o !== 1'b1 && ending_err_o !== 1'b1; i++) begin
            @(negedge core_clk_i);
            if (exec_go_o === 1'b1) begin
                goes++;
                chk(exec_cmd_o, channel_command_word_i);
                {last_ub, last_cyl} = {exec_use_buffer_o, exec_cyl_o};
            end
            last_disc |= disconnect_o;
        end
        wait_out(i, 400);
        chk(ending_ok_o, ok);
        chk(goes, n_go);
        if (!ok) chk(sense_cause_o, cause);
        if (m == 6'h02) begin
            chk({sense_pattern_o, sense_disp_o}, {err_pattern_i, err_disp_i});
            host = field_data_i ^ 64'(err_pattern_i) << 8 * err_disp_i[2:0];
            chk(host ^ 64'(sense_pattern_o) << 8 * sense_disp_o[2:0], field_data_i);
        end
        if (ok && n_go > 1) begin
            exp_log++;
            repeat (3) @(negedge core_clk_i);
            chk(log_rdata_o[15:4], {channel_command_word_i, 1'b0, cause});
        end
        chk(log_count_o, exp_log);
    endtask
    task automatic reject(input logic [8:0] c, input logic [4:0] h, input logic [13:0] l);
        @(posedge core_clk_i);
        {cmd_start_i, cmd_cyl_i, cmd_head_i, cmd_len_i} <= {1'b1, c, h, l};
        @(negedge core_clk_i);
        chk({cmd_reject_o, cmd_accept_o}, 2'h2);
        @(posedge core_clk_i);
        cmd_start_i <= 1'b0;
        @(negedge core_clk_i);
        chk(exec_go_o, 1'b0);
    endtask
    task automatic ecc(input int n, input logic bad);
        logic [7:0] e;
        logic [7:0] b;
        logic [7:0] got;
        logic       se;
        e = retry_pkg::ECC_SEED;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_i);
            b = 8'(xs());
            {wr_byte_valid_i, rd_byte_valid_i, wr_byte_i, rd_byte_i} <= {2'h3, b, b};
            e = {e[6:0], e[7]} ^ b;
        end
        @(posedge core_clk_i);
        {wr_byte_valid_i, rd_byte_valid_i, wr_area_end_i, rd_area_end_i} <= 4'h3;
        rd_ecc_i <= e ^ {7'h00, bad};
        @(posedge core_clk_i);
        {wr_area_end_i, rd_area_end_i} <= 2'h0;
        {got, se} = {~e, 1'b0};
        repeat (4) begin
            @(negedge core_clk_i);
            if (wr_ecc_valid_o === 1'b1) got = wr_ecc_o;
            if (rd_ecc_err_o === 1'b1) se = 1'b1;
        end
        chk(got, e);
        chk(se, bad);
    endtask
    initial begin
        {core_clk_i, rst_i, rng, n_fail, n_tests, exp_log} = {2'h1, 32'h00002D34, 64'h0, 6'h0};
        {ucode_valid_i, cmd_start_i, field_we_i, wr_byte_valid_i, wr_area_end_i} = '0;
        {rd_byte_valid_i, rd_area_end_i, load, mask, fails, lat, log_raddr_i} = '0;
        {ucode_byte_i, channel_command_word_i, wr_byte_i, rd_byte_i, rd_ecc_i} = '0;
        {cmd_cyl_i, cmd_head_i, cmd_len_i, err_pattern_i, err_disp_i, field_data_i} = '0;
        alt_cyl_i = 9'h0A3;
        alt_head_i = 5'h0C;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 4096; k++) begin
            @(posedge core_clk_i);
            {ucode_valid_i, ucode_byte_i} <= {1'b1, 8'(xs())};
            if (k == 4095) chk(online_o, 1'b0);
        end
        @(posedge core_clk_i);
        ucode_valid_i <= 1'b0;
        @(negedge core_clk_i);
        chk(online_o, 1'b1);
        reject(retry_pkg::LAST_CYL + 9'h001, 5'h00, 14'h0000);
        reject(9'h000, retry_pkg::LAST_HEAD + 5'h01, 14'h0000);
        reject(9'h000, 5'h00, retry_pkg::TRACK_BYTES_W + 14'h0001);
        run(6'h00, 4'h0, 1'b1, 1, 3'h0, 1'b1);
        run(6'h04, 4'h1, 1'b1, 2, retry_pkg::CAUSE_UNCORR, 1'b0);
        run(6'h04, 4'h2, 1'b1, 3, retry_pkg::CAUSE_UNCORR, 1'b0);
        run(6'h04, 4'h3, 1'b0, 3, retry_pkg::CAUSE_UNCORR, 1'b0);
        run(6'h08, 4'hA, 1'b1, 11, retry_pkg::CAUSE_SEEK, 1'b0);
        run(6'h08, 4'hB, 1'b0, 11, retry_pkg::CAUSE_SEEK, 1'b0);
        run(6'h10, 4'h1, 1'b1, 2, retry_pkg::CAUSE_ALT, 1'b0);
        chk(last_cyl, alt_cyl_i);
        run(6'h20, 4'h1, 1'b1, 2, retry_pkg::CAUSE_OVERRUN, 1'b0);
        run(6'h02, 4'h1, 1'b1, 1, retry_pkg::CAUSE_CORR, 1'b0);
        @(posedge core_clk_i);
        {field_we_i, field_data_i} <= {1'b1, xs(), xs()};
        @(posedge core_clk_i);
        field_we_i <= 1'b0;
        run(6'h01, 4'h1, 1'b1, 2, retry_pkg::CAUSE_CORR, 1'b0);
        chk({last_disc, last_ub}, 2'h3);
        chk(field_buf_o, field_data_i ^ (64'(err_pattern_i) << (8 * err_disp_i[2:0])));
        ecc(1, 1'b0);
        ecc(8 + int'(xs() % 24), 1'b0);
        ecc(5, 1'b1);
        tally_and_finish();
    end
endmodule
bind disk_command_retry_recovery retry_checker u_chk (.*);
`default_nettype wire
